// >>> sac_pkg.sv
// Package for the converter control block: register map, fields, codes, timing.
// Assumes a 32-bit classic Wishbone slave port and a 200 MHz system clock.
package sac_pkg;

   // Bus and data widths
   localparam int unsigned DAT_W  = 32;
   localparam int unsigned ADR_W  = 8;
   localparam int unsigned SEL_W  = 4;
   localparam int unsigned RES_W  = 10;
   localparam int unsigned CH_W   = 5;
   localparam int unsigned NUM_CH = 17;
   localparam int unsigned TSEL_W = 3;
   localparam int unsigned NUM_TMR = 4;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] OFS_MUX  = 8'h04;
   localparam logic [ADR_W-1:0] OFS_STAT = 8'h08;
   localparam logic [ADR_W-1:0] OFS_DATA = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_WLO  = 8'h10;
   localparam logic [ADR_W-1:0] OFS_WHI  = 8'h14;

   // Control register fields
   localparam int unsigned CTRL_SHUT    = 0;
   localparam int unsigned CTRL_TSEL_LO = 1;
   localparam int unsigned CTRL_BG      = 4;
   localparam int unsigned CTRL_WOUT    = 5;
   localparam int unsigned CTRL_DONE_IE = 6;
   localparam int unsigned CTRL_WIN_IE  = 7;
   localparam int unsigned CTRL_START   = 8;
   localparam int unsigned CTRL_W       = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;

   // Multiplexer register fields
   localparam int unsigned MUX_POS_LO = 0;
   localparam int unsigned MUX_NEG_LO = 8;

   // Status register fields
   localparam int unsigned STAT_DONE = 0;
   localparam int unsigned STAT_WIN  = 1;
   localparam int unsigned STAT_BUSY = 2;

   // Window bound reset values
   localparam logic [RES_W-1:0] WLO_RST = 10'h000;
   localparam logic [RES_W-1:0] WHI_RST = 10'h3FF;

   // Start-of-conversion source codes
   localparam logic [TSEL_W-1:0] TRIG_SW   = 3'h0;
   localparam logic [TSEL_W-1:0] TRIG_TMR0 = 3'h1;
   localparam logic [TSEL_W-1:0] TRIG_TMR3 = 3'h4;
   localparam logic [TSEL_W-1:0] TRIG_EXT  = 3'h5;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      SAC_IDLE = 3'b001,
      SAC_CONV = 3'b010,
      SAC_GAP  = 3'b100
   } sac_state_t;

   // Least start-to-start time at the highest sample rate, rounded up to cycles
   localparam int unsigned CLK_KHZ       = 200000;
   localparam int unsigned MAX_RATE_KSPS = 200;
   localparam int unsigned SAMPLE_CYCLES =
      (CLK_KHZ + MAX_RATE_KSPS - 1) / MAX_RATE_KSPS;
   localparam int unsigned CNT_W = 12;

endpackage

// >>> sac_window.sv
// Window comparator: flags a result inside, or outside, an inclusive range.
// Assumes lower and upper bounds come from registers; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sac_window #(
   parameter int unsigned WIDTH = sac_pkg::RES_W
) (
   input  wire logic [WIDTH-1:0] value_i,
   input  wire logic [WIDTH-1:0] lower_i,
   input  wire logic [WIDTH-1:0] upper_i,
   input  wire logic             outside_i,
   output logic                  hit_o
);

   logic in_range;

   // Refuse a width the comparison cannot serve
   if (WIDTH < 1 || WIDTH > 31) begin : g_bad_width
      $error("sac_window: WIDTH out of range");
   end

   // Range test, then choose inside or outside sense
   assign in_range = (value_i >= lower_i) && (value_i <= upper_i);
   assign hit_o    = outside_i ? ~in_range : in_range;

endmodule
`default_nettype wire

// >>> sac_ctrl.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes a classic Wishbone master, timer overflow pulses and a converter core
// that answers each start pulse with a one-cycle done pulse and its result.
// Notes on behaviour
// - Start source is software, timer 0 to 3 overflow, or external input.
// - With a timer selected, each overflow of it while the sequencer is idle starts a conversion.
// - Each completion sets the done flag; interrupt only when enabled.
// - Result is captured at completion and held until the next one.
// - Result is checked against bounds; hit inside or outside as configured.
// - Background mode converts repeatedly, interrupting only on window hits.
// - Software shutdown stops all conversions and powers the converter down.
// - Positive and negative inputs are selected independently, seventeen channels.
// - Starts may follow back to back at up to 200 ksps.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
   parameter int unsigned SAMPLE_CYC = sac_pkg::SAMPLE_CYCLES,
   parameter int unsigned NUM_CH     = sac_pkg::NUM_CH
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [sac_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [sac_pkg::SEL_W-1:0]  wb_sel_i,
   input  wire logic [sac_pkg::DAT_W-1:0]  wb_dat_i,
   output logic      [sac_pkg::DAT_W-1:0]  wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic [sac_pkg::NUM_TMR-1:0] timer_ovf_i,
   input  wire logic                       ext_start_i,
   input  wire logic                       conv_done_i,
   input  wire logic [sac_pkg::RES_W-1:0]  conv_data_i,
   output logic                            conv_start_o,
   output logic                            adc_en_o,
   output logic      [sac_pkg::CH_W-1:0]   mux_pos_o,
   output logic      [sac_pkg::CH_W-1:0]   mux_neg_o,
   output logic                            conv_irq_o,
   output logic                            win_irq_o
);

   localparam int unsigned RW = sac_pkg::RES_W;
   localparam int unsigned CW = sac_pkg::CH_W;
   localparam logic [sac_pkg::CNT_W-1:0] GAP_END = sac_pkg::CNT_W'(SAMPLE_CYC - 2);
   localparam logic [sac_pkg::CNT_W-1:0] CNT_MAX = '1;

   sac_pkg::sac_state_t state, next_state;
   logic [sac_pkg::CTRL_W-1:0] ctrl, next_ctrl;
   logic [CW-1:0]              pos_sel, next_pos_sel, neg_sel, next_neg_sel;
   logic [CW-1:0]              next_mux_pos, next_mux_neg;
   logic [RW-1:0]              result, next_result, win_lo, next_win_lo;
   logic [RW-1:0]              win_hi, next_win_hi;
   logic                       done_flag, next_done_flag, win_flag, next_win_flag;
   logic [sac_pkg::CNT_W-1:0]  cnt, next_cnt;
   logic                       ext_q, next_start, next_ack;
   logic [sac_pkg::DAT_W-1:0]  next_dat, wdata, rdata;
   logic                       bus_req, bus_wr, sw_go, trig, win_hit, cap;
   logic [sac_pkg::TSEL_W-1:0] tsel;
   logic                       shut, bg;

   // Refuse parameter values the sequencer or mux field cannot serve
   if (SAMPLE_CYC < 3 || SAMPLE_CYC > 4000) begin : g_bad_cyc
      $error("sac_ctrl: SAMPLE_CYC out of range");
   end
   if (NUM_CH < 2 || NUM_CH > (1 << CW)) begin : g_bad_ch
      $error("sac_ctrl: NUM_CH out of range");
   end

   // Byte-lane merge of a bus write into a register image
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Control field views
   assign shut    = ctrl[sac_pkg::CTRL_SHUT];
   assign bg      = ctrl[sac_pkg::CTRL_BG];
   assign tsel    = ctrl[sac_pkg::CTRL_TSEL_LO +: sac_pkg::TSEL_W];
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr  = bus_req & wb_we_i;
   assign cap     = (state == sac_pkg::SAC_CONV) & conv_done_i & ~shut;

   // Window test on the incoming sample, not the stored one
   sac_window #(
      .WIDTH (RW)
   ) u_window (
      .value_i   (conv_data_i),
      .lower_i   (win_lo),
      .upper_i   (win_hi),
      .outside_i (ctrl[sac_pkg::CTRL_WOUT]),
      .hit_o     (win_hit)
   );

   // Read mux: unmapped words read as zero
   always_comb begin
      rdata = '0;
      case (wb_adr_i)
         sac_pkg::OFS_CTRL: rdata[sac_pkg::CTRL_W-1:0] = ctrl;
         sac_pkg::OFS_MUX: begin
            rdata[sac_pkg::MUX_POS_LO +: CW] = pos_sel;
            rdata[sac_pkg::MUX_NEG_LO +: CW] = neg_sel;
         end
         sac_pkg::OFS_STAT: begin
            rdata[sac_pkg::STAT_DONE] = done_flag;
            rdata[sac_pkg::STAT_WIN]  = win_flag;
            rdata[sac_pkg::STAT_BUSY] = (state != sac_pkg::SAC_IDLE);
         end
         sac_pkg::OFS_DATA: rdata[RW-1:0] = result;
         sac_pkg::OFS_WLO:  rdata[RW-1:0] = win_lo;
         sac_pkg::OFS_WHI:  rdata[RW-1:0] = win_hi;
         default:           rdata = '0;
      endcase
   end

   // Trigger selection
   always_comb begin
      case (tsel)
         sac_pkg::TRIG_SW:  trig = sw_go;
         sac_pkg::TRIG_EXT: trig = ext_start_i & ~ext_q; // rising edge
         default: begin
            if (tsel >= sac_pkg::TRIG_TMR0 && tsel <= sac_pkg::TRIG_TMR3) begin
               trig = timer_ovf_i[2'(tsel - sac_pkg::TRIG_TMR0)];
            end else begin
               trig = 1'b0;
            end
         end
      endcase
   end

   // Next values: bus slave, status flags, sequencer
   always_comb begin
      next_ctrl      = ctrl;
      next_pos_sel   = pos_sel;
      next_neg_sel   = neg_sel;
      next_win_lo    = win_lo;
      next_win_hi    = win_hi;
      next_done_flag = done_flag;
      next_win_flag  = win_flag;
      next_result    = result;
      next_state     = state;
      next_cnt       = cnt;
      next_start     = 1'b0;
      next_mux_pos   = mux_pos_o;
      next_mux_neg   = mux_neg_o;
      next_ack       = bus_req;
      next_dat       = bus_req ? rdata : wb_dat_o;
      sw_go          = 1'b0;
      wdata          = '0;
      if (bus_wr) begin
         case (wb_adr_i)
            sac_pkg::OFS_CTRL: begin
               wdata = lane_merge(32'(ctrl), wb_dat_i, wb_sel_i);
               next_ctrl = wdata[sac_pkg::CTRL_W-1:0];
               sw_go = wdata[sac_pkg::CTRL_START] & wb_sel_i[1];
            end
            sac_pkg::OFS_MUX: begin
               wdata = lane_merge({19'h00000, neg_sel, 3'h0, pos_sel}, wb_dat_i, wb_sel_i);
               // independent inputs, codes past the last channel kept out
               if (32'(wdata[sac_pkg::MUX_POS_LO +: CW]) < NUM_CH) begin
                  next_pos_sel = wdata[sac_pkg::MUX_POS_LO +: CW];
               end
               if (32'(wdata[sac_pkg::MUX_NEG_LO +: CW]) < NUM_CH) begin
                  next_neg_sel = wdata[sac_pkg::MUX_NEG_LO +: CW];
               end
            end
            sac_pkg::OFS_STAT: begin
               // Write one to clear
               if (wb_sel_i[0] && wb_dat_i[sac_pkg::STAT_DONE]) begin
                  next_done_flag = 1'b0;
               end
               if (wb_sel_i[0] && wb_dat_i[sac_pkg::STAT_WIN]) begin
                  next_win_flag = 1'b0;
               end
            end
            sac_pkg::OFS_WLO: begin
               wdata = lane_merge(32'(win_lo), wb_dat_i, wb_sel_i);
               next_win_lo = wdata[RW-1:0];
            end
            sac_pkg::OFS_WHI: begin
               wdata = lane_merge(32'(win_hi), wb_dat_i, wb_sel_i);
               next_win_hi = wdata[RW-1:0];
            end
            default: wdata = '0;
         endcase
      end
      if (next_cnt != CNT_MAX) begin
         next_cnt = cnt + 1'b1;
      end
      case (state)
         sac_pkg::SAC_IDLE: begin
            // background mode restarts on its own
            if (!shut && (trig || bg)) begin
               next_start   = 1'b1;
               next_cnt     = '0;
               next_mux_pos = pos_sel;
               next_mux_neg = neg_sel;
               next_state   = sac_pkg::SAC_CONV;
            end
         end
         sac_pkg::SAC_CONV: begin
            if (cap) begin
               next_result    = conv_data_i;
               next_done_flag = 1'b1;
               if (win_hit) begin
                  next_win_flag = 1'b1;
               end
               next_state = sac_pkg::SAC_GAP;
            end
         end
         sac_pkg::SAC_GAP: begin
            // hold off until the sample period ends
            if (cnt >= GAP_END) begin
               next_state = sac_pkg::SAC_IDLE;
            end
         end
         default: next_state = sac_pkg::SAC_IDLE;
      endcase
      if (shut) begin
         next_state = sac_pkg::SAC_IDLE;
         next_start = 1'b0;
      end
   end

   // Register everything
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= sac_pkg::SAC_IDLE;
         ctrl      <= sac_pkg::CTRL_RST;
         pos_sel   <= '0;
         neg_sel   <= '0;
         win_lo    <= sac_pkg::WLO_RST;
         win_hi    <= sac_pkg::WHI_RST;
         done_flag <= 1'b0;
         win_flag  <= 1'b0;
         result    <= '0;
         cnt       <= '0;
         ext_q     <= 1'b0;
         conv_start_o <= 1'b0;
         mux_pos_o <= '0;
         mux_neg_o <= '0;
         wb_ack_o  <= 1'b0;
         wb_dat_o  <= '0;
      end else begin
         state     <= next_state;
         ctrl      <= next_ctrl;
         pos_sel   <= next_pos_sel;
         neg_sel   <= next_neg_sel;
         win_lo    <= next_win_lo;
         win_hi    <= next_win_hi;
         done_flag <= next_done_flag;
         win_flag  <= next_win_flag;
         result    <= next_result;
         cnt       <= next_cnt;
         ext_q     <= ext_start_i;
         conv_start_o <= next_start;
         mux_pos_o <= next_mux_pos;
         mux_neg_o <= next_mux_neg;
         wb_ack_o  <= next_ack;
         wb_dat_o  <= next_dat;
      end
   end

   // Interrupt requests and power enable
   // completion interrupt gated, silent in background mode
   assign conv_irq_o = done_flag & ctrl[sac_pkg::CTRL_DONE_IE] & ~bg;
   assign win_irq_o  = win_flag & ctrl[sac_pkg::CTRL_WIN_IE];
   assign adc_en_o   = ~shut;

   // Helper: cycles since the last start, for spacing checks
   logic [sac_pkg::CNT_W-1:0] since;
   logic                      seen;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since <= '0;
         seen  <= 1'b0;
      end else if (conv_start_o) begin
         since <= '0;
         seen  <= 1'b1;
      end else if (since != CNT_MAX) begin
         since <= since + 1'b1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   start_cause_a: assert property (
      conv_start_o |-> $past(!shut && (trig || bg) && state == sac_pkg::SAC_IDLE))
      else $error("start without a selected trigger");
   timer_start_a: assert property (
      (state == sac_pkg::SAC_IDLE && !shut && !bg && tsel == sac_pkg::TRIG_TMR0
       && timer_ovf_i[0] && !bus_wr) |=> conv_start_o)
      else $error("timer overflow did not start");
   ext_start_a: assert property (
      (state == sac_pkg::SAC_IDLE && !shut && tsel == sac_pkg::TRIG_EXT && !bus_wr
       && ext_start_i && !ext_q) |=> conv_start_o)
      else $error("external start ignored");
   done_set_a: assert property (
      cap |=> done_flag ##0 state == sac_pkg::SAC_GAP)
      else $error("done flag not set");
   irq_gate_a: assert property (
      conv_irq_o |-> done_flag && !bg && ctrl[sac_pkg::CTRL_DONE_IE])
      else $error("completion irq not gated");
   result_hold_a: assert property (
      !cap |=> $stable(result))
      else $error("result changed without completion");
   result_cap_a: assert property (
      cap |=> result == $past(conv_data_i))
      else $error("result not captured");
   win_irq_a: assert property (
      win_irq_o |-> win_flag && ctrl[sac_pkg::CTRL_WIN_IE])
      else $error("window irq not gated");
   bg_quiet_a: assert property (
      (bg && cap && !bus_wr) |=> done_flag && !conv_irq_o)
      else $error("background mode notified completion");
   bg_repeat_a: assert property (
      (state == sac_pkg::SAC_GAP && cnt >= GAP_END && !shut) ##1 (bg && !shut)
      |=> conv_start_o)
      else $error("background mode did not restart");
   shut_block_a: assert property (
      $past(shut) |-> !conv_start_o && state == sac_pkg::SAC_IDLE)
      else $error("conversion while shut down");
   mux_hold_a: assert property (
      (state == sac_pkg::SAC_CONV && $past(state) == sac_pkg::SAC_CONV)
      |-> $stable(mux_pos_o) && $stable(mux_neg_o))
      else $error("mux changed mid conversion");
   spacing_a: assert property (
      (conv_start_o && seen) |-> 32'(since) >= SAMPLE_CYC - 1)
      else $error("starts too close together");
   win_same_a: assert property (
      (cap && win_hit) |=> win_flag && done_flag)
      else $error("window flag not with completion");

   sw_conv_c:  cover property (sw_go && tsel == sac_pkg::TRIG_SW ##1 conv_start_o);
   win_hit_c:  cover property (cap && win_hit);
   bg_run_c:   cover property (bg && conv_start_o && seen);
   ext_conv_c: cover property (tsel == sac_pkg::TRIG_EXT && conv_start_o);

endmodule
`default_nettype wire

// >>> sac_core_model.sv
// Behavioural converter core that faces the conversion control block.
// Assumes one-cycle start pulses and answers each with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module sac_core_model #(
   parameter int unsigned LAT = 3
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [9:0] value_i,
   output logic            done_o,
   output logic [9:0]      data_o
);
   int unsigned cnt;
   logic        busy;
   logic [9:0]  last;

   // Count down after a start; data is only valid with done, else inverted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy   <= 1'b0;
         cnt    <= 0;
         done_o <= 1'b0;
         last   <= 10'h155;
         data_o <= 10'h2AA;
      end else begin
         done_o <= 1'b0;
         data_o <= ~last;
         if (start_i) begin
            busy <= 1'b1;
            cnt  <= LAT;
         end else if (busy && cnt == 0) begin
            busy   <= 1'b0;
            done_o <= 1'b1;
            data_o <= value_i;
            last   <= value_i;
         end else if (busy) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the converter control block.
// Assumes the block's Wishbone slave, and the core model on its converter side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int unsigned SC = 8;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic        cyc         = 1'b0;
   logic        stb         = 1'b0;
   logic        we          = 1'b0;
   logic [7:0]  adr         = 8'h00;
   logic [31:0] wdat        = 32'h0;
   logic [3:0]  sel         = 4'hF;
   logic [31:0] rdat;
   logic        ack;
   logic [3:0]  tmr         = 4'h0;
   logic        ext         = 1'b0;
   logic [9:0]  core_val    = 10'h000;
   logic        done;
   logic [9:0]  cdata;
   logic        conv_start_o;
   logic        adc_en_o;
   logic [4:0]  mux_pos_o;
   logic [4:0]  mux_neg_o;
   logic        conv_irq_o;
   logic        win_irq_o;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cycles      = 0;
   logic [31:0] q;

   // Clock at 200 MHz
   always #2.5 clk_i = ~clk_i;

   sac_ctrl #(.SAMPLE_CYC(SC), .NUM_CH(17)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer_ovf_i(tmr), .ext_start_i(ext), .conv_done_i(done), .conv_data_i(cdata),
      .conv_start_o(conv_start_o), .adc_en_o(adc_en_o), .mux_pos_o(mux_pos_o),
      .mux_neg_o(mux_neg_o), .conv_irq_o(conv_irq_o), .win_irq_o(win_irq_o));

   sac_core_model #(.LAT(3)) i_core (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o), .value_i(core_val),
      .done_o(done), .data_o(cdata));

   task automatic end_sim;
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 20) chk("bus ack", 32'h1, 32'h0);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // Watch for a start pulse from the edge just passed, for a bounded span;
   // a software start shows already at the edge where the bus task saw ack
   task automatic see_start(input string nm, input int lim, input logic e);
      logic seen;
      seen = 1'b0;
      repeat (lim) begin
         if (conv_start_o === 1'b1) seen = 1'b1;
         @(posedge clk_i);
      end
      chk(nm, {31'h0, e}, {31'h0, seen});
   endtask

   task automatic pulse_tmr(input int k);
      @(posedge clk_i);
      tmr <= 4'h1 << k;
      @(posedge clk_i);
      tmr <= 4'h0;
   endtask

   task automatic t_reset;
      rd("ctrl", 8'h00, 32'h1);
      rd("mux", 8'h04, 32'h0);
      rd("stat", 8'h08, 32'h0);
      rd("data", 8'h0C, 32'h0);
      rd("wlo", 8'h10, 32'h0);
      rd("whi", 8'h14, 32'h3FF);
      bus(1'b1, 8'h18, 32'hFFFF);
      rd("unmapped", 8'h18, 32'h0);
      chk("adc_en", 32'h0, {31'h0, adc_en_o});
   endtask

   task automatic t_sw;
      core_val <= 10'h2A5;
      bus(1'b1, 8'h00, 32'h40);
      bus(1'b1, 8'h00, 32'h140);
      see_start("sw start", 12, 1'b1);
      rd("data", 8'h0C, 32'h2A5);
      rd("stat", 8'h08, 32'h3);
      chk("done irq", 32'h1, {31'h0, conv_irq_o});
      bus(1'b1, 8'h08, 32'h3);
      chk("done irq clr", 32'h0, {31'h0, conv_irq_o});
      core_val <= 10'h0F0;
      // Start bit without its byte lane enabled must not start
      sel <= 4'h1;
      bus(1'b1, 8'h00, 32'h140);
      sel <= 4'hF;
      see_start("no start", 3 * SC, 1'b0);
      rd("data held", 8'h0C, 32'h2A5);
   endtask

   task automatic t_src;
      for (int k = 1; k <= 4; k++) begin
         bus(1'b1, 8'h00, 32'h40 | (k << 1));
         pulse_tmr(k % 4);
         see_start("other timer", SC + 4, 1'b0);
         pulse_tmr(k - 1);
         see_start("own timer", SC + 4, 1'b1);
      end
      bus(1'b1, 8'h00, 32'h4A);
      @(posedge clk_i);
      ext <= 1'b1;
      see_start("ext edge", SC, 1'b1);
      see_start("ext level", 2 * SC, 1'b0);
      ext <= 1'b0;
      // Unused source code starts nothing
      bus(1'b1, 8'h00, 32'h4C);
      pulse_tmr(0);
      see_start("no source", SC + 4, 1'b0);
   endtask

   task automatic t_mux;
      bus(1'b1, 8'h00, 32'h40);
      bus(1'b1, 8'h04, 32'h0310);
      bus(1'b1, 8'h00, 32'h140);
      see_start("mux start", 12, 1'b1);
      chk("mux pos", 32'h10, {27'h0, mux_pos_o});
      chk("mux neg", 32'h3, {27'h0, mux_neg_o});
      bus(1'b1, 8'h04, 32'h0011);
      rd("mux bad code", 8'h04, 32'h0010);
   endtask

   task automatic t_win;
      bus(1'b1, 8'h10, 32'h100);
      bus(1'b1, 8'h14, 32'h200);
      bus(1'b1, 8'h08, 32'h3);
      core_val <= 10'h100;
      bus(1'b1, 8'h00, 32'h180);
      repeat (SC + 2) @(posedge clk_i);
      chk("win in", 32'h1, {31'h0, win_irq_o});
      chk("done irq off", 32'h0, {31'h0, conv_irq_o});
      rd("stat in", 8'h08, 32'h3);
      bus(1'b1, 8'h08, 32'h3);
      core_val <= 10'h201;
      bus(1'b1, 8'h00, 32'h180);
      repeat (SC + 2) @(posedge clk_i);
      rd("stat out", 8'h08, 32'h1);
      chk("win none", 32'h0, {31'h0, win_irq_o});
      bus(1'b1, 8'h00, 32'h1A0);
      repeat (SC + 2) @(posedge clk_i);
      chk("win outside", 32'h1, {31'h0, win_irq_o});
      bus(1'b1, 8'h08, 32'h3);
   endtask

   task automatic t_bg;
      int n;
      int gap;
      int mingap;
      n = 0;
      gap = 0;
      mingap = 1000;
      core_val <= 10'h150;
      bus(1'b1, 8'h00, 32'hF0);
      repeat (6 * SC) begin
         @(posedge clk_i);
         gap++;
         if (conv_start_o === 1'b1) begin
            if (n > 0 && gap < mingap) mingap = gap;
            n++;
            gap = 0;
         end
         if (conv_irq_o !== 1'b0) n = -100;
      end
      chk("bg repeats", 32'h1, {31'h0, n >= 4});
      chk("bg rate", 32'h1, {31'h0, mingap >= SC});
      chk("bg quiet", 32'h0, {31'h0, win_irq_o});
      core_val <= 10'h300;
      repeat (2 * SC + 4) @(posedge clk_i);
      chk("bg window", 32'h1, {31'h0, win_irq_o});
   endtask

   task automatic t_shut;
      bus(1'b1, 8'h00, 32'hF1);
      repeat (SC) @(posedge clk_i);
      chk("shut en", 32'h0, {31'h0, adc_en_o});
      see_start("shut none", 3 * SC, 1'b0);
   endtask

   // Ceiling on the whole run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_sw();
      t_src();
      t_mux();
      t_win();
      t_bg();
      t_shut();
      end_sim();
   end
endmodule
`default_nettype wire
